// ### inc/snc_pkg.sv
package snc_pkg;
  localparam int NUM_LINKS = 8;
  localparam int IDX_W = 8;
  localparam logic [7:0] IDX_CLKGEN = 8'h06;
  localparam logic [7:0] IDX_SWDIV = 8'h07;
  localparam logic [7:0] IDX_REFDIV = 8'h08;
  localparam logic [7:0] IDX_DIRUP = 8'h0D;
  localparam logic [7:0] IDX_SPARE_A = 8'h10;
  localparam logic [7:0] IDX_SPARE_B = 8'h11;
  localparam logic [7:0] IDX_DBG = 8'h1F;
  localparam logic [7:0] IDX_LINK0 = 8'h20;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  localparam logic [7:0] IDX_NONE = 8'hFF;
  localparam int CG_N_LSB = 0;
  localparam int CG_N_W = 7;
  localparam int CG_M_LSB = 8;
  localparam int CG_M_W = 13;
  localparam int CG_P_LSB = 23;
  localparam int CG_P_W = 3;
  localparam logic [6:0] CG_N_RST = 7'h00;
  localparam logic [12:0] CG_M_RST = 13'h0000;
  localparam logic [2:0] CG_P_RST = 3'h0;
  localparam logic [15:0] SWDIV_RST = 16'h0000;
  localparam logic [15:0] REFDIV_RST = 16'h0003;
  localparam logic [31:0] DIRUP_RST = 32'h0000_0000;
  localparam logic [1:0] SPARE_RST = 2'h0;
  localparam logic [1:0] DBG_RST = 2'h0;
  localparam int DBG_RSV_BIT = 4;
  localparam logic [3:0] LK_DIR_RST = 4'h0;
  localparam logic [1:0] LK_NET_RST = 2'h0;
  localparam int IRQ_DBG = 0;
  localparam int IRQ_JUNK = 1;
  localparam int IRQ_W = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  typedef enum logic [1:0] {
    serial_channel_kind,
    processor_channel_kind,
    switch_control_target,
    kind_undefined
  } snc_src_kind_t;

  typedef struct packed {
    logic wr;
    logic [7:0] idx;
    logic [31:0] wdata;
  } snc_bus_req_t;

  typedef struct packed {
    snc_src_kind_t kind;
    logic [7:0] dst_link;
    logic junk;
    logic dst_busy;
    logic src_busy;
  } snc_link_stat_t;

  typedef struct packed {
    logic [2:0] out_div;
    logic [12:0] fb_mult;
    logic [6:0] in_div;
  } snc_clkgen_t;
endpackage

// ### verilog/snc_tick_div.sv
`timescale 1ns/1ps
module snc_tick_div #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] ratio,
  output logic tick
);
  logic [W-1:0] cnt_ff;
  logic tick_ff;
  wire wrap = (cnt_ff >= ratio);
  wire [W-1:0] nxt_cnt = wrap ? '0 : W'(cnt_ff + 1'b1);

  // One pulse every ratio+1 cycles; a ratio cut below the count wraps at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;
endmodule

// ### verilog/snc_ahb_slv.sv
`timescale 1ns/1ps
module snc_ahb_slv
  import snc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output snc_pkg::snc_bus_req_t req
);
  import snc_pkg::*;
  logic ph_ff;
  logic wait_ff;
  logic wr_ff;
  logic [7:0] idx_ff;
  logic [31:0] hrdata_ff;

  wire accept = hsel & htrans[1] & hready;
  // Addresses above the map land on an empty index and read zero
  wire [7:0] nxt_idx = (haddr[31:10] != 22'h0) ? IDX_NONE : haddr[9:2];

  // One wait state lets read data leave a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ff <= 1'b0;
      wait_ff <= 1'b0;
      wr_ff <= 1'b0;
      idx_ff <= IDX_NONE;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      if (accept) begin
        ph_ff <= 1'b1;
        wait_ff <= 1'b1;
        wr_ff <= hwrite;
        idx_ff <= nxt_idx;
      end else if (ph_ff && !wait_ff) begin
        ph_ff <= 1'b0;
      end
      if (ph_ff && wait_ff) begin
        wait_ff <= 1'b0;
        hrdata_ff <= wr_ff ? 32'h0000_0000 : rdata;
      end
    end
  end

  assign hreadyout = ~(ph_ff & wait_ff);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign req.wr = ph_ff & ~wait_ff & wr_ff;
  assign req.idx = idx_ff;
  assign req.wdata = hwdata;
endmodule

// ### verilog/snc_node_regs.sv
// Summary of operation
// - Input divider field, bits 6:0; bit 7 reads zero
// - Feedback multiplier 20:8, output divider 25:23
// - Switch divider 15:0, resets 0, upper zero
// - Reference divider 15:0, resets to 3
// - Eight direction nibbles, dimensions 8 to F
// - Debug origin: bit0 core 0, bit1 core 1
// - Link bits 25:24 show source target kind
// - Link bits 23:16 show forwarding destination link
// - Per-link direction 11:8, network 5:4, RW
// - Link bit 2 flags junk packet discard
// - Bit1 destination busy, bit0 source busy
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module snc_node_regs
  import snc_pkg::*;
#(
  parameter int LINKS = NUM_LINKS,
  parameter int DIV_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic global_debug_event,
  input wire logic [1:0] debug_core_origin,
  input wire snc_pkg::snc_link_stat_t link_stat [LINKS],
  output snc_pkg::snc_clkgen_t clkgen_cfg,
  output logic switch_tick,
  output logic ref_tick,
  output logic [31:0] dir_table_upper,
  output logic [3:0] link_dir [LINKS],
  output logic [1:0] link_net [LINKS],
  output logic [1:0] spare_a_bits,
  output logic [1:0] spare_b_bits,
  output logic irq
);
  import snc_pkg::*;

  function automatic logic wr_hit(input snc_bus_req_t r, input logic [7:0] i);
    return r.wr && (r.idx == i);
  endfunction

  function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] i);
    return a == i;
  endfunction

  snc_bus_req_t req;
  logic [31:0] rdata;

  snc_ahb_slv u_slv (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .rdata(rdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req)
  );

  // Clock generator settings
  logic [6:0] cg_n_ff;
  logic [12:0] cg_m_ff;
  logic [2:0] cg_p_ff;
  wire cg_wr = wr_hit(req, IDX_CLKGEN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cg_n_ff <= CG_N_RST;
      cg_m_ff <= CG_M_RST;
      cg_p_ff <= CG_P_RST;
    end else if (cg_wr) begin
      cg_n_ff <= req.wdata[CG_N_LSB +: CG_N_W];
      cg_m_ff <= req.wdata[CG_M_LSB +: CG_M_W];
      cg_p_ff <= req.wdata[CG_P_LSB +: CG_P_W];
    end
  end

  assign clkgen_cfg.in_div = cg_n_ff;
  assign clkgen_cfg.fb_mult = cg_m_ff;
  assign clkgen_cfg.out_div = cg_p_ff;

  // Bit 7 and bits 22:21, 31:26 stay zero on read
  wire [31:0] cg_word = {6'h00, cg_p_ff, 2'h0, cg_m_ff, 1'b0, cg_n_ff};

  // Switch and reference clock dividers
  logic [DIV_W-1:0] swdiv_ff;
  logic [DIV_W-1:0] refdiv_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swdiv_ff <= DIV_W'(SWDIV_RST);
      refdiv_ff <= DIV_W'(REFDIV_RST);
    end else begin
      if (wr_hit(req, IDX_SWDIV)) begin
        swdiv_ff <= req.wdata[DIV_W-1:0];
      end
      if (wr_hit(req, IDX_REFDIV)) begin
        refdiv_ff <= req.wdata[DIV_W-1:0];
      end
    end
  end

  // The ratio steers a live enable, so a new value takes effect within one period
  snc_tick_div #(.W(DIV_W)) u_swdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .ratio(swdiv_ff),
    .tick(switch_tick)
  );

  snc_tick_div #(.W(DIV_W)) u_refdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .ratio(refdiv_ff),
    .tick(ref_tick)
  );

  wire [31:0] swdiv_word = 32'(swdiv_ff);
  wire [31:0] refdiv_word = 32'(refdiv_ff);

  // Direction table for dimensions 8 to F, one nibble each
  logic [31:0] dirup_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dirup_ff <= DIRUP_RST;
    end else if (wr_hit(req, IDX_DIRUP)) begin
      dirup_ff <= req.wdata;
    end
  end

  assign dir_table_upper = dirup_ff;

  // Spare registers with no function
  logic [1:0] spare_a_ff;
  logic [1:0] spare_b_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spare_a_ff <= SPARE_RST;
      spare_b_ff <= SPARE_RST;
    end else begin
      if (wr_hit(req, IDX_SPARE_A)) begin
        spare_a_ff <= req.wdata[1:0];
      end
      if (wr_hit(req, IDX_SPARE_B)) begin
        spare_b_ff <= req.wdata[1:0];
      end
    end
  end

  assign spare_a_bits = spare_a_ff;
  assign spare_b_bits = spare_b_ff;

  // Debug origin: a fresh event overrides a software write in the same cycle
  logic [1:0] dbg_ff;
  logic dbg_rsv_ff;
  wire dbg_wr = wr_hit(req, IDX_DBG);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_ff <= DBG_RST;
      dbg_rsv_ff <= 1'b0;
    end else begin
      if (global_debug_event) begin
        dbg_ff <= debug_core_origin;
      end else if (dbg_wr) begin
        dbg_ff <= req.wdata[1:0];
      end
      if (dbg_wr) begin
        dbg_rsv_ff <= req.wdata[DBG_RSV_BIT];
      end
    end
  end

  wire [31:0] dbg_word = {27'h0, dbg_rsv_ff, 2'h0, dbg_ff};

  // Per-link registers
  logic [31:0] link_word [LINKS];
  logic [LINKS-1:0] junk_rise;

  for (genvar g = 0; g < LINKS; g++) begin : g_link
    logic [3:0] dir_ff;
    logic [1:0] net_ff;
    logic junk_d_ff;
    snc_link_stat_t st;
    assign st = link_stat[g];
    wire lk_wr = wr_hit(req, 8'(IDX_LINK0 + g));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dir_ff <= LK_DIR_RST;
        net_ff <= LK_NET_RST;
        junk_d_ff <= 1'b0;
      end else begin
        junk_d_ff <= st.junk;
        if (lk_wr) begin
          dir_ff <= req.wdata[11:8];
          net_ff <= req.wdata[5:4];
        end
      end
    end

    assign link_dir[g] = dir_ff;
    assign link_net[g] = net_ff;
    assign junk_rise[g] = st.junk & ~junk_d_ff;
    // Status fields are read live from the switch, writes to them are dropped
    assign link_word[g] = {6'h00,
                           st.kind,
                           st.dst_link,
                           4'h0, dir_ff, 2'h0, net_ff, 1'b0,
                           st.junk,
                           st.dst_busy,
                           st.src_busy};
  end

  // Interrupts: sticky status, write one to clear, set beats clear
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  wire [IRQ_W-1:0] irq_evt = {|junk_rise, global_debug_event};
  wire [IRQ_W-1:0] irq_clr = wr_hit(req, IDX_IRQ_STAT) ? req.wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_ff <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_hit(req, IDX_IRQ_MASK)) begin
        irq_mask_ff <= req.wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read selection; anything unmapped reads zero
  wire [7:0] ra = req.idx;
  wire link_sel = (ra >= IDX_LINK0) && (ra < 8'(IDX_LINK0 + LINKS));
  wire [7:0] link_off = 8'(ra - IDX_LINK0);
  wire [31:0] link_rd = link_sel ? link_word[link_off[2:0]] : 32'h0000_0000;

  assign rdata = ({32{rd_hit(ra, IDX_CLKGEN)}} & cg_word)
               | ({32{rd_hit(ra, IDX_SWDIV)}} & swdiv_word)
               | ({32{rd_hit(ra, IDX_REFDIV)}} & refdiv_word)
               | ({32{rd_hit(ra, IDX_DIRUP)}} & dirup_ff)
               | ({32{rd_hit(ra, IDX_SPARE_A)}} & {30'h0, spare_a_ff})
               | ({32{rd_hit(ra, IDX_SPARE_B)}} & {30'h0, spare_b_ff})
               | ({32{rd_hit(ra, IDX_DBG)}} & dbg_word)
               | ({32{rd_hit(ra, IDX_IRQ_STAT)}} & 32'(irq_stat_ff))
               | ({32{rd_hit(ra, IDX_IRQ_MASK)}} & 32'(irq_mask_ff))
               | link_rd;
endmodule

// ### verif/snc_node_regs_checker.sv
`timescale 1ns/1ps
module snc_node_regs_checker
  import snc_pkg::*;
#(
  parameter int LINKS = NUM_LINKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire snc_pkg::snc_link_stat_t link_stat [LINKS],
  input wire snc_pkg::snc_clkgen_t clkgen_cfg,
  input wire logic [31:0] dir_table_upper,
  input wire logic [3:0] link_dir [LINKS],
  input wire logic [1:0] link_net [LINKS],
  input wire logic [1:0] spare_a_bits
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Upper address bits set means unmapped, so those transfers are excluded
  wire logic tk = hsel && htrans[1] && hready && haddr[31:10] == 22'h0;
  wire logic wr = tk && hwrite;
  wire logic rd = tk && !hwrite;
  wire logic [7:0] ix = haddr[9:2];
  property p_in_div;
    wr && ix == IDX_CLKGEN |-> ##3 clkgen_cfg.in_div == $past(hwdata[6:0], 2);
  endproperty
  a_in_div: assert property (p_in_div) else $error("input divider not loaded");
  property p_mult_div;
    wr && ix == IDX_CLKGEN |-> ##3
      {clkgen_cfg.out_div, clkgen_cfg.fb_mult} == {$past(hwdata[25:23], 2), $past(hwdata[20:8], 2)};
  endproperty
  a_mult_div: assert property (p_mult_div) else $error("multiplier or divider wrong");
  property p_dir_up;
    wr && ix == IDX_DIRUP |-> ##3 dir_table_upper == $past(hwdata, 2);
  endproperty
  a_dir_up: assert property (p_dir_up) else $error("direction table not loaded");
  property p_link_cfg;
    wr && ix == IDX_LINK0 |-> ##3
      {link_dir[0], link_net[0]} == {$past(hwdata[11:8], 2), $past(hwdata[5:4], 2)};
  endproperty
  a_link_cfg: assert property (p_link_cfg) else $error("link config not loaded");
  property p_spare;
    wr && ix == IDX_SPARE_A |-> ##3 spare_a_bits == $past(hwdata[1:0], 2);
  endproperty
  a_spare: assert property (p_spare) else $error("spare bits not loaded");
  property p_kind;
    rd && ix == IDX_LINK0 |-> ##2 hrdata[25:24] == $past(link_stat[0].kind);
  endproperty
  a_kind: assert property (p_kind) else $error("source kind misread");
  property p_dst;
    rd && ix == IDX_LINK0 |-> ##2 hrdata[23:16] == $past(link_stat[0].dst_link);
  endproperty
  a_dst: assert property (p_dst) else $error("destination link misread");
  property p_flags;
    rd && ix == IDX_LINK0 |-> ##2 hrdata[2:0] ==
      {$past(link_stat[0].junk), $past(link_stat[0].dst_busy), $past(link_stat[0].src_busy)};
  endproperty
  a_flags: assert property (p_flags) else $error("link flags misread");
  property p_rsv;
    rd && ix == IDX_LINK0 |-> ##2 (hrdata & 32'hFC00_F0C8) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved link bits not zero");
endmodule

bind snc_node_regs snc_node_regs_checker #(.LINKS(LINKS)) u_chk (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .link_stat, .clkgen_cfg,
  .dir_table_upper, .link_dir, .link_net, .spare_a_bits);

// ### verif/switch_node_config_regs_tb.sv
`timescale 1ns/1ps
module switch_node_config_regs_tb;
  import snc_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, swt, rft, irq;
  logic gde = 1'h0;
  logic [1:0] org = 2'h0;
  snc_link_stat_t ls [NUM_LINKS];
  snc_clkgen_t cg;
  logic [31:0] dtu;
  logic [3:0] ldir [NUM_LINKS];
  logic [1:0] lnet [NUM_LINKS];
  logic [1:0] spa, spb;
  logic [31:0] q [$];
  logic rd_ph = 1'h0;
  int fails = 0;
  int n_checks = 0;
  int seed = 90;
  logic [7:0] ix [9] = '{8'h06, 8'h07, 8'h08, 8'h0D, 8'h10, 8'h11, 8'h1F, 8'h28, 8'h05};
  logic [31:0] mk [9] = '{32'h039F_FF7F, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF, 32'h3, 32'h3,
    32'h13, 32'h0, 32'h0};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  always #50 hclk = ~hclk;

  snc_node_regs DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .global_debug_event(gde),
    .debug_core_origin(org), .link_stat(ls), .clkgen_cfg(cg), .switch_tick(swt),
    .ref_tick(rft), .dir_table_upper(dtu), .link_dir(ldir), .link_net(lnet),
    .spare_a_bits(spa), .spare_b_bits(spb), .irq);

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready sampled high at a rising edge
  task automatic hwait();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 20) begin
        fails++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a, 2'h0};
    hwait();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= w ? d : $random(seed);
    hwait();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    xfer(1'h0, a, 32'h0);
  endtask

  // Align to one tick, then count cycles to the next
  task automatic per(input logic r, output int n);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while ((r ? rft : swt) !== 1'h1 && n < 99);
    end
  endtask

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'h1 && q.size() > 0) begin
      chk(hrdata, q.pop_front());
    end
    if (hreadyout === 1'h1) begin
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
  end

  initial begin
    logic [31:0] d;
    logic [31:0] dbg;
    snc_link_stat_t s;
    int n;
    dbg = 32'h0;
    foreach (ls[i]) ls[i] = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    per(1'h0, n);
    chk(n, 1);
    per(1'h1, n);
    chk(n, 4);
    for (int i = 0; i < 9; i++) rd(ix[i], rv[i]);
    for (int i = 0; i < 9; i++) begin
      d = $random(seed);
      wr(ix[i], d);
      rd(ix[i], d & mk[i]);
      if (ix[i] == 8'h06) chk(32'(cg), 32'({d[25:23], d[20:8], d[6:0]}));
      if (ix[i] == 8'h0D) chk(dtu, d);
      if (ix[i] == 8'h10) chk({30'h0, spa}, d & 32'h3);
      if (ix[i] == 8'h11) chk({30'h0, spb}, d & 32'h3);
      chk({31'h0, hresp}, 32'h0);
      if (ix[i] == 8'h1F) dbg = d;
    end
    for (int l = 0; l < NUM_LINKS; l++) begin
      d = $random(seed);
      s = snc_link_stat_t'(13'($random(seed)));
      ls[l] <= s;
      wr(8'h20 + 8'(l), d);
      rd(8'h20 + 8'(l), {6'h0, s[12:3], 4'h0, d[11:8], 2'h0, d[5:4], 1'h0, s[2:0]});
      chk({26'h0, ldir[l], lnet[l]}, {26'h0, d[11:8], d[5:4]});
    end
    wr(8'h07, 32'hFFFF_0005);
    per(1'h0, n);
    chk(n, 6);
    wr(8'h08, 32'h0002_0002);
    per(1'h1, n);
    chk(n, 3);
    wr(8'h31, 32'h0);
    wr(8'h30, 32'h3);
    for (int k = 1; k < 3; k++) begin
      gde <= 1'h1;
      org <= 2'(k);
      @(posedge hclk);
      gde <= 1'h0;
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h30, 32'h1);
      rd(8'h1F, (dbg & 32'h10) | 32'(k));
      wr(8'h31, 32'h1);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      wr(8'h30, 32'h1);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(8'h31, 32'h0);
    end
    conclude();
  end
endmodule
